// *** core/iftd_pkg.sv ***
// Package for the instruction format and timing decoder.
// Assumes a 14-bit instruction word and a four-phase instruction cycle.
package iftd_pkg;

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int WORD_W = 14;
  localparam int FILE_ADDR_W = 7;
  localparam int BIT_NUM_W = 3;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  localparam int MODE_W = 2;
  localparam int DEST_POS = 7;
  localparam int BIT_NUM_LSB = 7;
  localparam int LIT11_MSB = 10;
  localparam int PTR_IDX_POS = 2;
  localparam int CAT_MSB = 13;
  localparam int CAT_LSB = 12;
  localparam logic [6:0] FILE_ADDR_MAX = 7'h7F;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int PHASES_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_FETCH = 2'h0;
  localparam logic [1:0] CYCLES_ONE = 2'h1;
  localparam logic [1:0] CYCLES_TWO = 2'h2;

  // ----------------------------------------------------------------------
  // Categories and opcode patterns
  // ----------------------------------------------------------------------
  localparam logic [1:0] CAT_BYTE_CODE = 2'h0;
  localparam logic [1:0] CAT_BIT_CODE = 2'h1;
  localparam logic [13:0] OP_CALL_MASK = 14'h3800;
  localparam logic [13:0] OP_CALL = 14'h2000;
  localparam logic [13:0] OP_JUMP = 14'h2800;
  localparam logic [13:0] OP_BRA_MASK = 14'h3E00;
  localparam logic [13:0] OP_BRA = 14'h3200;
  localparam logic [13:0] OP_CALL_VIA_ACCUMULATOR = 14'h000A;
  localparam logic [13:0] OP_BRW = 14'h000B;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETURN_FROM_INTERRUPT_I = 14'h0009;
  localparam logic [13:0] OP_RETURN_WITH_LITERAL_MASK = 14'h3F00;
  localparam logic [13:0] OP_RETURN_WITH_LITERAL = 14'h3400;
  localparam logic [13:0] OP_INC_MASK = 14'h3FF8;
  localparam logic [13:0] OP_PTR_STEP = 14'h0010;
  localparam logic [13:0] OP_SKIP_BYTE_MASK = 14'h3B00;
  localparam logic [13:0] OP_SKIP_BYTE = 14'h0B00;
  localparam logic [13:0] OP_SKIP_BIT_MASK = 14'h3800;
  localparam logic [13:0] OP_SKIP_BIT = 14'h1800;
  localparam logic [13:0] OP_FILE_BYTE_MASK = 14'h3C00;
  localparam logic [13:0] OP_FILE_BYTE_HI = 14'h3400;
  localparam logic [13:0] OP_MOVWF_MASK = 14'h3F80;
  localparam logic [13:0] OP_MOVWF = 14'h0080;
  localparam logic [13:0] OP_CLRF = 14'h0180;
  localparam logic [13:0] OP_NOP = 14'h0000;

  typedef enum logic [1:0] {
    IFTD_CAT_BYTE,
    IFTD_CAT_BIT,
    IFTD_CAT_LITERAL
  } iftd_cat_type;

  typedef enum logic [1:0] {
    IFTD_STEP_PRE_INC,
    IFTD_STEP_PRE_DEC,
    IFTD_STEP_POST_INC,
    IFTD_STEP_POST_DEC
  } iftd_step_type;

endpackage

// *** core/iftd_phase_gen.sv ***
// Phase generator: splits the oscillator clock into four-phase cycles.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module iftd_phase_gen (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  output logic [1:0] phase_o,
  output logic cycle_end_o
);

  typedef struct packed {
    logic [1:0] phase;
    logic cycle_end;
  } iftd_pg_state_type;

  iftd_pg_state_type st_ff;
  iftd_pg_state_type nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.phase = st_ff.phase + 2'h1;
    nxt_st.cycle_end = (nxt_st.phase == iftd_pkg::PHASE_LAST);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign phase_o = st_ff.phase;
  assign cycle_end_o = st_ff.cycle_end;

endmodule
`default_nettype wire

// *** core/iftd_decoder.sv ***
// Instruction format and timing decoder for a 14-bit instruction core.
// Assumes instruction words arrive from logic on the same clock, along with
// skip and pointer-target flags computed by the datapath.
// Functional notes
// - Instruction words are exactly 14 bits, opcode plus all operands.
// - Every opcode sorts into byte, bit, or literal-and-control category.
// - Instructions complete in one instruction cycle unless an exception applies.
// - Call and call-via-accumulator take two instruction cycles.
// - Return, return-with-literal and return-from-interrupt take two cycles.
// - Jumps, branches, and taken skips take two instruction cycles.
// - Indirect access with pointer into program memory adds one cycle.
// - One instruction cycle is four oscillator clocks.
// - File-register instructions always read; byte ops write back only with bit 7 set, bit ops unless a bit test.
// - Destination bit 0 sends result to accumulator, 1 to the file.
// - File address selects 0x00 to 0x7F in the current bank.
// - Bit number selects one bit of an 8-bit register.
// - Pointer index selects indirect pointer pair 0 or 1.
// - Two-bit step mode picks pre/post increment/decrement.
// - Don't-care bits are ignored; sources should drive them zero.
// - Byte format: opcode 13:8, destination bit 7, address 6:0.
// - Bit format: opcode 13:10, bit number 9:7, address 6:0.
// - Literal format: opcode 13:8, 8-bit literal 7:0.
// - Call and jump: opcode 13:11, 11-bit target 10:0.
`timescale 1ns/10ps
`default_nettype none
module iftd_decoder (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [13:0] instr_word_i,
  input wire logic skip_taken_i,
  input wire logic indirect_ref_i,
  input wire logic pointer_in_prog_i,
  output logic cycle_end_o,
  output logic [1:0] phase_o,
  output logic [1:0] category_o,
  output logic [6:0] file_addr_o,
  output logic dest_to_file_o,
  output logic dest_to_accum_o,
  output logic [2:0] bit_num_o,
  output logic [7:0] bit_mask_o,
  output logic [7:0] literal8_o,
  output logic [10:0] target11_o,
  output logic pointer_index_o,
  output logic [1:0] pointer_step_mode_o,
  output logic file_read_o,
  output logic file_write_o,
  output logic [1:0] cycle_count_o,
  output logic extra_cycle_o,
  output logic flush_o,
  output logic nop_exec_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic cycle_end;
    logic [1:0] phase;
    logic [1:0] category;
    logic [6:0] file_addr;
    logic dest_to_file;
    logic dest_to_accum;
    logic [2:0] bit_num;
    logic [7:0] bit_mask;
    logic [7:0] literal8;
    logic [10:0] target11;
    logic pointer_index;
    logic [1:0] step_mode;
    logic file_read;
    logic file_write;
    logic [1:0] cycle_count;
    logic extra_cycle;
    logic flush;
    logic nop_exec;
    logic pending_nop;
    logic pending_extra;
  } iftd_dec_state_type;

  iftd_dec_state_type st_ff;
  iftd_dec_state_type nxt_st;

  logic [1:0] gen_phase;
  logic gen_cycle_end;

  iftd_phase_gen u_phase (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .phase_o(gen_phase),
    .cycle_end_o(gen_cycle_end)
  );

  // ----------------------------------------------------------------------
  // Combinational classification of the current word
  // ----------------------------------------------------------------------
  logic [13:0] w;
  iftd_pkg::iftd_cat_type cat;
  logic is_call;
  logic is_jump;
  logic is_bra;
  logic is_ret;
  logic is_skip;
  logic is_file_op;
  logic is_write_only;
  logic two_cycle;
  logic [7:0] mask;

  always_comb
  begin
    w = instr_word_i;
    if (w[iftd_pkg::CAT_MSB:iftd_pkg::CAT_LSB] == iftd_pkg::CAT_BYTE_CODE)
    begin
      cat = iftd_pkg::IFTD_CAT_BYTE;
    end
    else if (w[iftd_pkg::CAT_MSB:iftd_pkg::CAT_LSB] == iftd_pkg::CAT_BIT_CODE)
    begin
      cat = iftd_pkg::IFTD_CAT_BIT;
    end
    // The carry and shift file ops live in the upper literal prefix.
    else if (w[iftd_pkg::CAT_MSB:iftd_pkg::CAT_LSB] == 2'h3
             && (w[11:8] == 4'h5 || w[11:8] == 4'h6 || w[11:8] == 4'h7
             || w[11:8] == 4'hB || w[11:8] == 4'hD))
    begin
      cat = iftd_pkg::IFTD_CAT_BYTE;
    end
    else
    begin
      cat = iftd_pkg::IFTD_CAT_LITERAL;
    end
    // Low-range control words share the byte prefix; byte ops never use
    // bits 13:7 all zero (opcode 00 with bit 7 clear), so any such word is a control word.
    if (cat == iftd_pkg::IFTD_CAT_BYTE && w[13:7] == 7'h00)
    begin
      cat = iftd_pkg::IFTD_CAT_LITERAL;
    end
    is_call = ((w & iftd_pkg::OP_CALL_MASK) == iftd_pkg::OP_CALL)
              || (w == iftd_pkg::OP_CALL_VIA_ACCUMULATOR);
    is_jump = ((w & iftd_pkg::OP_CALL_MASK) == iftd_pkg::OP_JUMP);
    is_bra = ((w & iftd_pkg::OP_BRA_MASK) == iftd_pkg::OP_BRA)
             || (w == iftd_pkg::OP_BRW);
    is_ret = (w == iftd_pkg::OP_RETURN) || (w == iftd_pkg::OP_RETURN_FROM_INTERRUPT_I)
             || ((w & iftd_pkg::OP_RETURN_WITH_LITERAL_MASK) == iftd_pkg::OP_RETURN_WITH_LITERAL);
    is_skip = ((w & iftd_pkg::OP_SKIP_BYTE_MASK) == iftd_pkg::OP_SKIP_BYTE)
              || ((w & iftd_pkg::OP_SKIP_BIT_MASK) == iftd_pkg::OP_SKIP_BIT);
    is_file_op = (cat != iftd_pkg::IFTD_CAT_LITERAL);
    is_write_only = ((w & iftd_pkg::OP_MOVWF_MASK) == iftd_pkg::OP_MOVWF)
                    || ((w & iftd_pkg::OP_MOVWF_MASK) == iftd_pkg::OP_CLRF);
    two_cycle = is_call || is_ret || is_jump || is_bra
                || (is_skip && skip_taken_i);
    mask = 8'h01 << w[iftd_pkg::BIT_NUM_LSB +: iftd_pkg::BIT_NUM_W];
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.phase = gen_phase;
    nxt_st.cycle_end = gen_cycle_end;
    nxt_st.flush = 1'b0;
    if (gen_phase == iftd_pkg::PHASE_FETCH)
    begin
      if (st_ff.pending_nop)
      begin
        // The prefetched word is stale after a change of flow.
        nxt_st.pending_nop = 1'b0;
        nxt_st.nop_exec = 1'b1;
        nxt_st.file_read = 1'b0;
        nxt_st.file_write = 1'b0;
        nxt_st.extra_cycle = 1'b0;
      end
      else if (st_ff.pending_extra)
      begin
        // Hold the decoded fields while the extra cycle completes.
        nxt_st.pending_extra = 1'b0;
        nxt_st.extra_cycle = 1'b1;
        nxt_st.file_read = 1'b0;
        nxt_st.file_write = 1'b0;
        nxt_st.nop_exec = 1'b0;
      end
      else
      begin
        nxt_st.nop_exec = 1'b0;
        nxt_st.extra_cycle = 1'b0;
        nxt_st.category = cat;
        // Don't-care bits are simply not looked at by any field below.
        nxt_st.file_addr = w[iftd_pkg::FILE_ADDR_W-1:0];
        nxt_st.dest_to_file = w[iftd_pkg::DEST_POS];
        nxt_st.dest_to_accum = ~w[iftd_pkg::DEST_POS];
        nxt_st.bit_num = w[iftd_pkg::BIT_NUM_LSB +: iftd_pkg::BIT_NUM_W];
        nxt_st.bit_mask = mask;
        nxt_st.literal8 = w[iftd_pkg::LIT8_W-1:0];
        nxt_st.target11 = w[iftd_pkg::LIT11_MSB:0];
        nxt_st.pointer_index = w[iftd_pkg::PTR_IDX_POS];
        nxt_st.step_mode = w[iftd_pkg::MODE_W-1:0];
        // A write-only file op still reads its register first.
        nxt_st.file_read = is_file_op;
        // Bit 7 is part of the bit number in bit ops, so only byte ops obey it.
        nxt_st.file_write = (cat == iftd_pkg::IFTD_CAT_BYTE
                             && (w[iftd_pkg::DEST_POS] || is_write_only))
                            || (cat == iftd_pkg::IFTD_CAT_BIT && !is_skip);
        nxt_st.cycle_count = two_cycle ? iftd_pkg::CYCLES_TWO
                                       : iftd_pkg::CYCLES_ONE;
        nxt_st.pending_nop = two_cycle;
        nxt_st.flush = two_cycle;
        nxt_st.pending_extra = indirect_ref_i && pointer_in_prog_i;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------
  assign cycle_end_o = st_ff.cycle_end;
  assign phase_o = st_ff.phase;
  assign category_o = st_ff.category;
  assign file_addr_o = st_ff.file_addr;
  assign dest_to_file_o = st_ff.dest_to_file;
  assign dest_to_accum_o = st_ff.dest_to_accum;
  assign bit_num_o = st_ff.bit_num;
  assign bit_mask_o = st_ff.bit_mask;
  assign literal8_o = st_ff.literal8;
  assign target11_o = st_ff.target11;
  assign pointer_index_o = st_ff.pointer_index;
  assign pointer_step_mode_o = st_ff.step_mode;
  assign file_read_o = st_ff.file_read;
  assign file_write_o = st_ff.file_write;
  assign cycle_count_o = st_ff.cycle_count;
  assign extra_cycle_o = st_ff.extra_cycle;
  assign flush_o = st_ff.flush;
  assign nop_exec_o = st_ff.nop_exec;

endmodule
`default_nettype wire

// *** verification/iftd_decoder_asserts.sv ***
// Concurrent checks on the decoder's ports.
// Assumes it is bound to iftd_decoder; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module iftd_decoder_asserts (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [13:0] instr_word_i,
  input wire logic indirect_ref_i,
  input wire logic pointer_in_prog_i,
  input wire logic cycle_end_o,
  input wire logic [1:0] phase_o,
  input wire logic [6:0] file_addr_o,
  input wire logic dest_to_file_o,
  input wire logic dest_to_accum_o,
  input wire logic [7:0] bit_mask_o,
  input wire logic file_read_o,
  input wire logic file_write_o,
  input wire logic [1:0] cycle_count_o,
  input wire logic extra_cycle_o,
  input wire logic flush_o,
  input wire logic nop_exec_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Word, flags and cycle end as they stood at the previous edge, the take.
  logic [13:0] word_ff;
  logic end_ff;
  logic ind_prog_ff;
  logic take;
  always @(posedge core_clk_i)
  begin
    word_ff <= instr_word_i;
    end_ff <= cycle_end_o;
    ind_prog_ff <= indirect_ref_i && pointer_in_prog_i;
  end
  // Refused cycles hold stale fields, so they are left out here.
  assign take = end_ff && !nop_exec_o && !extra_cycle_o;
  phase_wrap_a: assert property (phase_o == 2'h3 |=> phase_o == 2'h0)
    else $error("phase did not wrap");
  cycle_end_a: assert property (cycle_end_o == (phase_o == 2'h3))
    else $error("cycle end off phase");
  addr_field_a: assert property (take |-> file_addr_o == word_ff[6:0])
    else $error("file address wrong");
  dest_pair_a: assert property (take |-> dest_to_file_o == word_ff[7]
    && dest_to_accum_o != dest_to_file_o) else $error("destination wrong");
  bit_mask_a: assert property (take |-> bit_mask_o == 8'h01 << word_ff[9:7])
    else $error("bit mask wrong");
  rmw_read_a: assert property (file_write_o |-> file_read_o)
    else $error("write without read");
  flush_once_a: assert property (flush_o |-> (cycle_count_o == 2'h2) ##1 !flush_o)
    else $error("flush pulse wrong");
  nop_after_a: assert property (flush_o |-> ##4 nop_exec_o && !file_read_o)
    else $error("no-op missing");
  extra_after_a: assert property (take && ind_prog_ff && !flush_o |-> ##4 extra_cycle_o)
    else $error("extra cycle missing");
  call_two_a: assert property (take && (word_ff & 14'h3800) == 14'h2000
    |-> cycle_count_o == 2'h2) else $error("call not two cycles");
  flush_c: cover property (flush_o);
  extra_c: cover property (extra_cycle_o);
  write_c: cover property (file_write_o);
endmodule
`default_nettype wire

// *** verification/iftd_prog_mem.sv ***
// Program memory model supplying words and datapath flags.
// Assumes the bench fills mem and flg before reset is released.
`timescale 1ns/10ps
`default_nettype none
module iftd_prog_mem (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic cycle_end_i,
  output logic [13:0] word_o,
  output logic [2:0] flag_o
);
  logic [13:0] mem [0:255];
  logic [2:0] flg [0:255];
  int pc;
  int idx;
  logic took_ff;
  // The decoder takes a word at reset release and at the edge after each
  // cycle end, so the next word follows one edge later and stands for a cycle.
  always @(posedge core_clk_i)
  begin
    idx = sys_rst_i ? 0 : pc;
    if (sys_rst_i || took_ff)
    begin
      word_o <= mem[idx];
      flag_o <= flg[idx];
      pc <= idx + 1;
    end
    took_ff <= sys_rst_i || cycle_end_i;
  end
endmodule
`default_nettype wire

// *** verification/iftd_decoder_tb.sv ***
// Self-checking bench for the instruction format and timing decoder.
// Assumes the decoder, checker and memory model compile before it.
`timescale 1ns/10ps
`default_nettype none
module iftd_decoder_tb;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [13:0] word;
  logic [2:0] flg;
  logic [1:0] phase_o, category_o, pointer_step_mode_o, cycle_count_o;
  logic [6:0] file_addr_o;
  logic [2:0] bit_num_o;
  logic [7:0] bit_mask_o, literal8_o;
  logic [10:0] target11_o;
  logic cycle_end_o, dest_to_file_o, dest_to_accum_o, pointer_index_o;
  logic file_read_o, file_write_o, extra_cycle_o, flush_o, nop_exec_o;
  logic [49:0] got;
  logic [49:0] exp_q [$];
  logic [49:0] msk_q [$];
  logic run_ff = 1'b0;
  logic [31:0] seed = 32'h3A0A4D8F;
  logic [13:0] r;
  int n = 0;
  int fails = 0;
  int comparisons = 0;
  always #50 core_clk_i = ~core_clk_i;
  iftd_prog_mem u_mem (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .cycle_end_i(cycle_end_o), .word_o(word), .flag_o(flg));
  iftd_decoder DUT (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .instr_word_i(word),
    .skip_taken_i(flg[2]), .indirect_ref_i(flg[1]), .pointer_in_prog_i(flg[0]),
    .cycle_end_o(cycle_end_o), .phase_o(phase_o), .category_o(category_o),
    .file_addr_o(file_addr_o), .dest_to_file_o(dest_to_file_o),
    .dest_to_accum_o(dest_to_accum_o), .bit_num_o(bit_num_o), .bit_mask_o(bit_mask_o),
    .literal8_o(literal8_o), .target11_o(target11_o), .pointer_index_o(pointer_index_o),
    .pointer_step_mode_o(pointer_step_mode_o), .file_read_o(file_read_o),
    .file_write_o(file_write_o), .cycle_count_o(cycle_count_o),
    .extra_cycle_o(extra_cycle_o), .flush_o(flush_o), .nop_exec_o(nop_exec_o));
  assign got = {bit_num_o, file_write_o, category_o, file_addr_o, dest_to_file_o, bit_mask_o,
    literal8_o, target11_o, pointer_index_o, pointer_step_mode_o, cycle_count_o, flush_o,
    file_read_o, nop_exec_o, extra_cycle_o};
  function automatic logic [13:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[13:0];
  endfunction
  task automatic put(input logic [13:0] w, input logic [2:0] f);
    u_mem.mem[n] = w;
    u_mem.flg[n] = f;
    n++;
  endtask
  // -----------------------------------------------------------------
  // Loads one word and notes every instruction cycle it should cost.
  // -----------------------------------------------------------------
  task automatic add(input logic [13:0] w, input logic [2:0] f);
    logic two;
    logic wr;
    logic [1:0] cat;
    two = (w & 14'h3800) == 14'h2000 || (w & 14'h3800) == 14'h2800
      || (w & 14'h3E00) == 14'h3200 || w == 14'h000A || w == 14'h000B
      || w == 14'h0008 || w == 14'h0009 || (w & 14'h3F00) == 14'h3400
      || f[2] && ((w & 14'h3B00) == 14'h0B00 || (w & 14'h3800) == 14'h1800);
    cat = w[13:12] == 2'h1 ? 2'h1 : ((w[13:12] == 2'h0 && |w[13:7]) || (w[13:12] == 2'h3
      && (w[11:8] == 4'h5 || w[11:8] == 4'h6 || w[11:8] == 4'h7 || w[11:8] == 4'hB
      || w[11:8] == 4'hD))) ? 2'h0 : 2'h2;
    // Bit ops other than the bit tests always store back; byte ops obey bit 7.
    wr = (cat == 2'h0 && w[7]) || (cat == 2'h1 && (w & 14'h3800) != 14'h1800);
    put(w, f);
    exp_q.push_back({w[9:7], wr, cat, w[6:0], w[7], 8'h01 << w[9:7], w[7:0], w[10:0], w[2],
      w[1:0], two ? 2'h2 : 2'h1, two, cat != 2'h2, 2'h0});
    msk_q.push_back({50{1'b1}});
    // The prefetched word in a refused slot is live junk, not a quiet no-op.
    if (two)
    begin
      put(rnd(), 3'h7);
      exp_q.push_back(50'h2);
      msk_q.push_back(50'hF);
    end
    if (f[1] && f[0])
    begin
      put(rnd(), 3'h7);
      exp_q.push_back(50'h1);
      msk_q.push_back(50'hB);
    end
  endtask
  task automatic chk(input logic [49:0] e, input logic [49:0] m, input logic [49:0] g);
    comparisons++;
    if ((g & m) !== (e & m))
    begin
      fails++;
      $display("BAD decode exp %h got %h", e & m, g & m);
    end
  endtask
  task automatic end_sim();
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk_i)
    run_ff <= !sys_rst_i;
  // The flush pulse only stands in the clock after a take, so look mid-clock there.
  always @(negedge core_clk_i)
  begin
    if (run_ff && !sys_rst_i && phase_o == iftd_pkg::PHASE_FETCH && exp_q.size() > 0)
    begin
      chk(exp_q.pop_front(), msk_q.pop_front(), got);
    end
  end
  initial
  begin
    // Idle slots hold zero words, with zeros in every unused position.
    for (int i = 0; i < 256; i++)
      put(14'h0, 3'h0);
    n = 0;
    add(14'h2005, 3'h0);
    add(14'h000A, 3'h0);
    add(14'h0008, 3'h0);
    add(14'h0009, 3'h0);
    add(14'h34AA, 3'h0);
    add(14'h2BFF, 3'h0);
    add(14'h321F, 3'h0);
    add(14'h000B, 3'h0);
    add(14'h0B85, 3'h4);
    add(14'h0F05, 3'h0);
    add(14'h1C12, 3'h4);
    add(14'h1812, 3'h0);
    add(14'h3DC5, 3'h0);
    for (int i = 0; i < 8; i++)
      add(14'h0010 | 14'(i), 3'h0);
    add(14'h0780, 3'h3);
    add(14'h2000, 3'h3);
    add(14'h077F, 3'h0);
    for (int i = 0; i < 40; i++)
    begin
      r = rnd();
      add(r[13] ? {2'h1, r[11:0]} : {2'h0, r[11:8] | 4'h2, r[7:0]}, r[2:0]);
    end
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 2000 && exp_q.size() > 0; i++)
      @(posedge core_clk_i);
    // Results still owed when the limit runs out count against the run.
    if (exp_q.size() > 0)
      fails++;
    repeat (2) @(posedge core_clk_i);
    end_sim();
  end
  initial
  begin
    repeat (3000) @(posedge core_clk_i);
    fails++;
    end_sim();
  end
endmodule
bind iftd_decoder iftd_decoder_asserts u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .instr_word_i(instr_word_i), .indirect_ref_i(indirect_ref_i),
  .pointer_in_prog_i(pointer_in_prog_i), .cycle_end_o(cycle_end_o), .phase_o(phase_o),
  .file_addr_o(file_addr_o), .dest_to_file_o(dest_to_file_o),
  .dest_to_accum_o(dest_to_accum_o), .bit_mask_o(bit_mask_o), .file_read_o(file_read_o),
  .file_write_o(file_write_o), .cycle_count_o(cycle_count_o),
  .extra_cycle_o(extra_cycle_o), .flush_o(flush_o), .nop_exec_o(nop_exec_o));
`default_nettype wire
